/* File: hw/edra_pkg.sv */
/*
 * constants and carriers for the dma channel activation-source block.
 * assumes a single 50 mhz bus clock; no register bus, mode bits are ports.
 */
// Function
// [RL1] two-bit select picks auto or pin activation
// [RL2] auto mode requests as soon as enabled
// [RL3] auto mode offers cycle-steal and burst modes
// [RL4] pin mode transfers only on low request
// [RL5] sense bit picks falling edge or level
// [RL6] acknowledge pulses once per accepted pin request
// [RL7] software sets request pin as input first
// [RL8] pin sampled every cycle after enable write
// [RL9] low sample latched, cleared at activation start
// [RL10] edge mode rearms after high seen by write end
// [RL11] delay bit holds off acceptance one cycle
// [RL12] level single mode reopens after clearance cycle
// [RL13] first acceptance always uses low-level sensing
// [RL14] requester must not hold pin low at reactivation; the bench holds it low before each reenable
// [RL15] disabled channel ignores pin, holds no request
package edra_pkg;
	// activation source selection codes
	localparam logic [1:0] SEL_AUTO = 2'h0;
	localparam logic [1:0] SEL_EXT = 2'h1;
	// clearance delay, in bus cycles, added by the delay bit
	localparam int unsigned CLEAR_CYCLES = 1;
	localparam logic ACK_IDLE = 1'h1;

	// mode bits of the channel mode register, carried together
	typedef struct packed {
		logic activation_select_hi;
		logic activation_select_lo;
		logic transfer_enable_bit;
		logic request_sense_select; // 1 = level, 0 = falling edge
		logic acknowledge_output_enable;
		logic next_request_delay;
		logic burst_mode; // 0 = cycle steal
		logic single_address_mode;
	} edra_mode_s;

	typedef enum logic [1:0] {
		ST_OPEN = 2'b00, // accepting low level
		ST_BUSY = 2'b01, // activation running
		ST_WAIT_HIGH = 2'b10, // edge mode: waiting for pin high
		ST_CLEAR = 2'b11 // delay bit clearance cycle
	} edra_state_e;
endpackage : edra_pkg

/* File: hw/edra_activation.sv */
/*
 * activation-source logic of one external-bus dma channel: auto-request or
 * active-low pin request, edge or level sensed, with acknowledge and delay.
 * assumes the transfer sequencer reports start, write-cycle end and done.
 */
`timescale 1ns/1ps
module edra_activation (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// mode bits
	input wire edra_pkg::edra_mode_s mode,
	input wire logic mode_write, // pulse: mode register write cycle ends
	// external pin
	input wire logic ext_request_n,
	output logic request_acknowledge_n,
	// transfer sequencer
	input wire logic xfer_start, // activation begins this cycle
	input wire logic write_end, // dma write / single cycle ends
	input wire logic xfer_done, // whole transfer ended
	output logic xfer_request,
	output logic xfer_burst,
	output logic request_pending
);
	logic rst_s1_q, rst_s2_q;
	logic pend_q, ack_q, seen_high_q, armed_q;
	edra_pkg::edra_state_e state_q;
	logic ext_mode, enabled, sample_ok, low_now;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'h0;
			rst_s2_q <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// source decode
	assign ext_mode = ({mode.activation_select_hi, mode.activation_select_lo}
		== edra_pkg::SEL_EXT); // [RL1]
	assign enabled = mode.transfer_enable_bit;
	// sampling waits one edge past the enabling write
	assign sample_ok = enabled && armed_q && !mode_write; // [RL8]
	assign low_now = !ext_request_n;

	// arm sampling after the write cycle has ended
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q)
			armed_q <= 1'h0;
		else if (clk_en)
			armed_q <= enabled && !mode_write; // [RL8] [RL15]
	end

	// acceptance sequencing; fresh start always level-senses
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			state_q <= edra_pkg::ST_OPEN;
		end else if (clk_en) begin
			if (!enabled || xfer_done) begin
				state_q <= edra_pkg::ST_OPEN; // [RL13]
			end else begin
				case (state_q)
					edra_pkg::ST_OPEN: begin
						if (xfer_start && ext_mode)
							state_q <= edra_pkg::ST_BUSY;
					end
					edra_pkg::ST_BUSY: begin
						if (write_end) begin
							if (mode.next_request_delay)
								state_q <= edra_pkg::ST_CLEAR; // [RL11] [RL12]
							else if (!mode.request_sense_select && !(seen_high_q || !low_now))
								state_q <= edra_pkg::ST_WAIT_HIGH; // [RL10]
							else
								state_q <= edra_pkg::ST_OPEN;
						end
					end
					edra_pkg::ST_WAIT_HIGH: begin
						if (!low_now)
							state_q <= edra_pkg::ST_OPEN; // [RL5] [RL10]
					end
					edra_pkg::ST_CLEAR: begin
						// edge mode still needs a high after clearance
						if (!mode.request_sense_select && !(seen_high_q || !low_now))
							state_q <= edra_pkg::ST_WAIT_HIGH;
						else
							state_q <= edra_pkg::ST_OPEN; // [RL11]
					end
					default: state_q <= edra_pkg::ST_OPEN;
				endcase
			end
		end
	end

	// high seen on the pin since activation started
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q)
			seen_high_q <= 1'h0;
		else if (clk_en) begin
			if (xfer_start)
				seen_high_q <= !low_now;
			else if (!low_now)
				seen_high_q <= 1'h1; // [RL10]
		end
	end

	// request latch; a new low in the start cycle is not accepted (acceptance closed)
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q)
			pend_q <= 1'h0;
		else if (clk_en) begin
			if (!enabled || !ext_mode)
				pend_q <= 1'h0; // [RL15]
			else if (xfer_start)
				pend_q <= 1'h0; // [RL9]
			else if (sample_ok && state_q == edra_pkg::ST_OPEN && low_now)
				pend_q <= 1'h1; // [RL9] [RL4]
		end
	end

	// acknowledge: one low cycle as processing of a pin request starts
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q)
			ack_q <= edra_pkg::ACK_IDLE;
		else if (clk_en)
			ack_q <= !(xfer_start && pend_q && ext_mode
				&& mode.acknowledge_output_enable); // [RL6]
	end

	// request to sequencer: auto asks whenever enabled; pin mode needs a latch
	assign xfer_request = enabled && (ext_mode ? pend_q : 1'h1); // [RL2] [RL4]
	assign xfer_burst = mode.burst_mode && !ext_mode; // [RL3]
	assign request_pending = pend_q;
	assign request_acknowledge_n = ack_q;

	// checks
	chk_disabled_clear: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && !enabled |=> !pend_q) // [RL15]
		else $error("pending request survives disable");
	chk_start_clears: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && xfer_start && enabled |=> !pend_q) // [RL9]
		else $error("request not cleared at activation");
	chk_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && xfer_start && pend_q && ext_mode && mode.acknowledge_output_enable
		|=> !request_acknowledge_n) // [RL6]
		else $error("acknowledge missing at start");
	chk_ack_gate: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!mode.acknowledge_output_enable && $stable(mode.acknowledge_output_enable)
		|=> request_acknowledge_n) // [RL6]
		else $error("acknowledge while disabled");
	chk_auto_request: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		enabled && !ext_mode |-> xfer_request) // [RL2]
		else $error("auto mode not requesting");
	chk_ext_request: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		ext_mode && xfer_request |-> pend_q) // [RL4]
		else $error("pin mode request without latch");
	chk_level_latch: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && ext_mode && sample_ok && state_q == edra_pkg::ST_OPEN && low_now
		&& !xfer_start |=> pend_q) // [RL9]
		else $error("low sample not latched");
	chk_delay_wait: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && enabled && !xfer_done && state_q == edra_pkg::ST_BUSY && write_end
		&& mode.next_request_delay |=> state_q == edra_pkg::ST_CLEAR) // [RL11]
		else $error("clearance cycle skipped");
	chk_edge_hold: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		clk_en && state_q == edra_pkg::ST_WAIT_HIGH && !xfer_start |=> !pend_q) // [RL10]
		else $error("request latched before high seen");
	chk_arm_late: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		mode_write |-> !sample_ok) // [RL8]
		else $error("sampled during enabling write");

	cov_auto: cover property (@(posedge core_clk) enabled && !ext_mode && xfer_start);
	cov_edge: cover property (@(posedge core_clk)
		state_q == edra_pkg::ST_WAIT_HIGH ##1 state_q == edra_pkg::ST_OPEN);
	cov_delay: cover property (@(posedge core_clk) state_q == edra_pkg::ST_CLEAR);
	cov_ack: cover property (@(posedge core_clk) !request_acknowledge_n);
endmodule : edra_activation

/* File: verification/edra_requester.sv */
/*
 * model of the external device that drives the active-low request pin.
 * assumes the bench commands it and the channel only samples the pin.
 */
`timescale 1ns/1ps
module edra_requester (
	// clock
	input wire logic core_clk,
	// command from bench
	input wire logic want_low,
	// request pin
	output logic ext_request_n
);
	// pin is an input on the channel side, so only this end drives it
	// follows the bench command, which changes on the falling edge, well clear of the
	// sampling edge; a second falling-edge process here would race the bench
	assign ext_request_n = ~want_low; // bench drives it low before each reenable
endmodule : edra_requester

/* File: verification/test_edra_activation.sv */
/*
 * bench for the activation-source block: mode writes, pin requests, transfers.
 * assumes the requester model drives the pin; clk_en drops low once for the freeze check.
 */
`timescale 1ns/1ps
module test_edra_activation;
	logic core_clk, rst_n, mode_write, want_low, xfer_start, write_end, xfer_done, clk_en;
	logic ext_request_n, request_acknowledge_n, xfer_request, xfer_burst, request_pending;
	edra_pkg::edra_mode_s mode;
	int mismatches, total_checks, cycles, n0, n1;
	edra_activation dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .mode(mode),
		.mode_write(mode_write), .ext_request_n(ext_request_n),
		.request_acknowledge_n(request_acknowledge_n), .xfer_start(xfer_start),
		.write_end(write_end), .xfer_done(xfer_done), .xfer_request(xfer_request),
		.xfer_burst(xfer_burst), .request_pending(request_pending));
	edra_requester req (.core_clk(core_clk), .want_low(want_low), .ext_request_n(ext_request_n));
	// free-running bus clock
	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	// hang guard, far above the fewer than one hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	task step(input int n);
		repeat (n) @(negedge core_clk);
	endtask : step
	task chk(input string what, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk
	task cfg(input logic [7:0] m);
		mode = m;
		mode_write = 1'h1;
		step(1);
		mode_write = 1'h0;
	endtask : cfg
	// bounded wait, counts falling edges until a request is latched
	task wait_pend(output int n);
		n = 0;
		while (request_pending !== 1'h1 && n < 20) begin
			step(1);
			n++;
		end
	endtask : wait_pend
	// one transfer: start, acknowledge check, write end
	task run_xfer(input logic ack_exp);
		xfer_start = 1'h1;
		step(1);
		xfer_start = 1'h0;
		chk("ack", request_acknowledge_n, ack_exp);
		chk("pend_clr", request_pending, 1'h0);
		step(1);
		chk("ack_end", request_acknowledge_n, 1'h1);
		write_end = 1'h1;
		step(1);
		write_end = 1'h0;
	endtask : run_xfer
	task off;
		want_low = 1'h0;
		cfg(8'h58);
		step(2);
		chk("off_pend", request_pending, 1'h0);
	endtask : off
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		{rst_n, mode_write, want_low, xfer_start, write_end, xfer_done} = '0;
		mode = '0;
		clk_en = 1'h1;
		step(16);
		rst_n = 1'h1;
		step(4);
		chk("rst_ack", request_acknowledge_n, 1'h1);
		chk("rst_pend", request_pending, 1'h0);
		want_low = 1'h1;
		cfg(8'h22); // auto, burst, pin low must not latch
		step(2);
		chk("auto_req", xfer_request, 1'h1);
		chk("auto_burst", xfer_burst, 1'h1);
		chk("auto_pend", request_pending, 1'h0);
		cfg(8'h20);
		chk("steal", xfer_burst, 1'h0);
		cfg(8'h58);
		step(4);
		chk("dis_req", xfer_request, 1'h0);
		$display("test auto and disable done");
		cfg(8'h79); // pin already low before the enabling write
		wait_pend(n0);
		chk("lvl_pend", request_pending, 1'h1);
		chk("lvl_req", xfer_request, 1'h1);
		// enable low freezes the latch even across a disabling write
		clk_en = 1'h0;
		cfg(8'h58);
		step(1);
		chk("freeze", request_pending, 1'h1);
		clk_en = 1'h1;
		cfg(8'h79);
		chk("thaw", request_pending, 1'h1);
		run_xfer(1'h0);
		wait_pend(n0);
		chk("lvl_again", request_pending, 1'h1);
		run_xfer(1'h0);
		off();
		want_low = 1'h1;
		cfg(8'h7d); // level, single address, delay bit
		wait_pend(n1);
		run_xfer(1'h0);
		wait_pend(n1);
		chk("delay", n1 == n0 + 1, 1'h1);
		run_xfer(1'h0);
		off();
		want_low = 1'h1;
		cfg(8'h71); // acknowledge disabled
		wait_pend(n1);
		run_xfer(1'h1);
		off();
		$display("test level done");
		want_low = 1'h1;
		cfg(8'h69); // edge sensing, first request still level
		wait_pend(n1);
		chk("edge_first", request_pending, 1'h1);
		run_xfer(1'h0);
		step(4);
		chk("edge_hold", request_pending, 1'h0);
		want_low = 1'h0;
		step(3);
		want_low = 1'h1;
		wait_pend(n1);
		chk("edge_rearm", request_pending, 1'h1);
		run_xfer(1'h0);
		want_low = 1'h0;
		xfer_done = 1'h1;
		step(1);
		xfer_done = 1'h0;
		off();
		$display("test edge done");
		print_verdict();
	end
endmodule : test_edra_activation
